// file: rtl/plbp_pkg.sv
// Package: constants and carrier types for the port latch and bus pin block
// Assumes a single core clock; the core sequencer supplies bus cycle requests
package plbp_pkg;

    // ------------------------------------------------------------------
    // Port geometry and reset values
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PORTS       = 5;
    localparam int unsigned PORT_WIDTH      = 8;
    localparam int unsigned PORT4_WIDTH     = 5;
    localparam logic [7:0]  LATCH_RESET_VAL = 8'hFF;
    localparam logic [2:0]  PORT_ID_P0      = 3'h0;
    localparam logic [2:0]  PORT_ID_P2      = 3'h2;
    localparam logic [2:0]  PORT_ID_P4      = 3'h4;

    // ------------------------------------------------------------------
    // Machine cycle timing in oscillator periods
    // ------------------------------------------------------------------
    localparam logic [3:0]  OSC_PER_MC_STD  = 4'hC;
    localparam logic [3:0]  OSC_PER_MC_X2   = 4'h6;
    // Address strobe at phase 0 and half cycle, so 1/6 (std) or 1/3 (x2)
    localparam logic [3:0]  STROBE_PH_A     = 4'h0;
    localparam logic [3:0]  STD_PH_B        = 4'h6;
    localparam logic [3:0]  X2_PH_B         = 4'h3;
    // Program store strobe phases within the machine cycle
    localparam logic [3:0]  STD_PS_A        = 4'h2;
    localparam logic [3:0]  STD_PS_B        = 4'h8;
    localparam logic [3:0]  X2_PS_A         = 4'h1;
    localparam logic [3:0]  X2_PS_B         = 4'h4;
    // Program store strobes skipped per external data access
    localparam logic [1:0]  PS_SKIP_COUNT   = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;     // Write strobe loads latch
        logic       rd;     // Read strobe
        logic       rmw;    // Read-modify-write: read the latch
        logic [2:0] port;   // Port select 0..4
        logic [7:0] wdata;
    } plbp_cpu_req_type;

    typedef struct packed {
        logic [7:0] addr_lo;  // Low address / data out on port 0
        logic [7:0] addr_hi;  // High address on port 2
        logic       p0_drive; // Port 0 drives data in this cycle
    } plbp_bus_addr_type;

endpackage

// file: rtl/plbp_port_block.sv
// Port latches, read paths, pin drivers and external bus strobes
// Assumes pins sampled through two flip-flops; oscillator enable from core
// Contract
// - Address strobe every 1/6 (1/3 x2) osc
// - Software may disable address strobe internally
// - Address strobe marks valid low address
// - Program strobe twice per external-fetch cycle
// - Skip two program strobes per data access
// - No program strobe for internal fetches
// - Fetch select held steady by board
// - Port bits are CPU-written D latches
// - Latch read returns stored values
// - Pin read returns sampled pin levels
// - Read-modify-write uses latch read path
// - Each port bit direction set independently
// - Ports 1,3,4: write one for input
// - Latch set lets alternate function drive
// - Ports 0,2: set bit disables driver
// - Port 0 unavailable as GPIO on bus
// - Port 2 unavailable as GPIO on bus
// - Port 0 pull-up only in bus cycles
// - Port 2 pull-up assists ones on bus
// - Bus cycle drivers take address/data lines
// - Reset sets all port latches to one
module plbp_port_block
    import plbp_pkg::*;
#(
    parameter int unsigned W = PORT_WIDTH
)
(
    input  wire logic                          core_clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic                          osc_tick_in,
    input  wire logic                          double_speed_mode_in,
    input  wire logic                          strobe_disable_in,
    input  wire logic                          xdata_access_in,
    input  wire logic                          bus_cycle_in,
    input  wire plbp_bus_addr_type             bus_addr_in,
    input  wire logic                          external_fetch_select_in,
    input  wire plbp_cpu_req_type              cpu_req_in,
    input  wire logic [NUM_PORTS*W-1:0]        alt_out_in,
    input  wire logic [NUM_PORTS*W-1:0]        pin_in,
    output logic [W-1:0]                       rdata_out,
    output logic [NUM_PORTS*W-1:0]             pin_out,
    output logic [NUM_PORTS*W-1:0]             pin_oe_n_out,
    output logic [2*W-1:0]                     strong_pull_out,
    output logic                               addr_latch_strobe_out,
    output logic                               program_store_strobe_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [NUM_PORTS*W-1:0] pin_meta_ff;
    logic [NUM_PORTS*W-1:0] pin_sync_ff;
    logic                   fetch_meta_ff;
    logic                   fetch_sync_ff;

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pin_meta_ff   <= '1;
            pin_sync_ff   <= '1;
            fetch_meta_ff <= 1'b1;
            fetch_sync_ff <= 1'b1;
        end
        else
        begin
            pin_meta_ff   <= pin_in;
            pin_sync_ff   <= pin_meta_ff;
            fetch_meta_ff <= external_fetch_select_in;
            fetch_sync_ff <= fetch_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Port latches
    // ------------------------------------------------------------------
    logic [W-1:0] latch_ff [NUM_PORTS];

    // Port 4 keeps only its implemented bits; upper bits read as zero
    function automatic logic [W-1:0] port_mask(input logic [2:0] idx);
        port_mask = (idx == PORT_ID_P4) ? W'((1 << PORT4_WIDTH) - 1) : '1;
    endfunction

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
                latch_ff[i] <= W'(LATCH_RESET_VAL) & port_mask(3'(i));
        end
        else if (cpu_req_in.wr && cpu_req_in.port < 3'(NUM_PORTS))
        begin
            latch_ff[cpu_req_in.port] <= cpu_req_in.wdata[W-1:0]
                                         & port_mask(cpu_req_in.port);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [W-1:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = '0;
        if (cpu_req_in.rd && cpu_req_in.port < 3'(NUM_PORTS))
        begin
            if (cpu_req_in.rmw)
                nxt_rdata = latch_ff[cpu_req_in.port];
            else
                nxt_rdata = pin_sync_ff[cpu_req_in.port*W +: W]
                            & port_mask(cpu_req_in.port);
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_out <= '0;
        else
            rdata_out <= nxt_rdata;
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    logic [NUM_PORTS*W-1:0] nxt_pin;
    logic [NUM_PORTS*W-1:0] nxt_oe_n;
    logic [2*W-1:0]         nxt_pull;

    always_comb
    begin
        nxt_pin  = '0;
        nxt_oe_n = '1;
        nxt_pull = '0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            for (int b = 0; b < W; b++)
            begin
                // Quasi-bidirectional: only a zero pulls low; latch one releases
                // the pull-down and the alternate output may then pull low
                nxt_pin[p*W+b]  = 1'b0;
                // Unbuilt port 4 bits stay released; no phantom pin is pulled low
                nxt_oe_n[p*W+b] = (latch_ff[p][b] & alt_out_in[p*W+b])
                                  | (p == int'(PORT_ID_P4)
                                     && b >= int'(PORT4_WIDTH));
            end
        end
        if (bus_cycle_in)
        begin
            // Bus owns ports 0 and 2; latches are bypassed, not altered
            nxt_pin[0 +: W]  = bus_addr_in.addr_lo;
            nxt_oe_n[0 +: W] = bus_addr_in.p0_drive ? '0 : '1;
            nxt_pull[0 +: W] = bus_addr_in.p0_drive ? bus_addr_in.addr_lo : '0;
            nxt_pin[2*W +: W]  = bus_addr_in.addr_hi;
            nxt_oe_n[2*W +: W] = '0;
            nxt_pull[W +: W]   = bus_addr_in.addr_hi;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pin_out         <= '0;
            pin_oe_n_out    <= '1;
            strong_pull_out <= '0;
        end
        else
        begin
            pin_out         <= nxt_pin;
            pin_oe_n_out    <= nxt_oe_n;
            strong_pull_out <= nxt_pull;
        end
    end

    // ------------------------------------------------------------------
    // Machine cycle phase counter
    // ------------------------------------------------------------------
    logic [3:0] phase_ff;
    logic [3:0] mc_len;

    assign mc_len = double_speed_mode_in ? OSC_PER_MC_X2 : OSC_PER_MC_STD;

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            phase_ff <= '0;
        else if (osc_tick_in)
            phase_ff <= (phase_ff >= mc_len - 4'h1) ? 4'h0 : phase_ff + 4'h1;
    end

    // ------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------
    logic       ale_phase;
    logic       ps_phase;
    logic [1:0] skip_ff;
    logic       nxt_ale;
    logic       nxt_ps;

    assign ale_phase = osc_tick_in && (phase_ff == STROBE_PH_A ||
                       phase_ff == (double_speed_mode_in ? X2_PH_B : STD_PH_B));
    assign ps_phase  = osc_tick_in &&
                       (phase_ff == (double_speed_mode_in ? X2_PS_A : STD_PS_A) ||
                        phase_ff == (double_speed_mode_in ? X2_PS_B : STD_PS_B));

    // Disable honoured only with internal fetch; external code needs the strobe
    assign nxt_ale = ale_phase && !xdata_access_in
                     && !(strobe_disable_in && fetch_sync_ff);

    assign nxt_ps  = ps_phase && !fetch_sync_ff && skip_ff == 2'h0;

    // An external data access during external fetch with no skip pending starts a skip of two program strobes
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            skip_ff <= '0;
        // Load only from a zero count; an access while a skip is pending starts no skip of its own
        else if (xdata_access_in && !fetch_sync_ff && skip_ff == 2'h0)
            skip_ff <= PS_SKIP_COUNT;
        else if (ps_phase && skip_ff != 2'h0)
            skip_ff <= skip_ff - 2'h1;
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            addr_latch_strobe_out    <= 1'b0;
            program_store_strobe_out <= 1'b0;
        end
        else
        begin
            addr_latch_strobe_out    <= nxt_ale;
            program_store_strobe_out <= nxt_ps;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_no_internal_ps: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $past(fetch_sync_ff) |-> !program_store_strobe_out)
        else $error("program strobe during internal fetch");

    a_ale_gated_xdata: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $past(xdata_access_in) |-> !addr_latch_strobe_out)
        else $error("address strobe during data access");

    a_ale_disable: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $past(strobe_disable_in && fetch_sync_ff) |-> !addr_latch_strobe_out)
        else $error("address strobe while disabled");

    a_ale_on_phase: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (osc_tick_in && phase_ff == STROBE_PH_A && !xdata_access_in && !strobe_disable_in)
        |=> addr_latch_strobe_out)
        else $error("address strobe missing");

    a_ps_ext_fetch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (ps_phase && !fetch_sync_ff && skip_ff == 2'h0) |=> program_store_strobe_out)
        else $error("program strobe missing");

    a_ps_skip: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (ps_phase && skip_ff != 2'h0) |=> !program_store_strobe_out)
        else $error("program strobe not skipped");

    a_rmw_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (cpu_req_in.rd && cpu_req_in.rmw && cpu_req_in.port == 3'h1 && !cpu_req_in.wr)
        |=> rdata_out == latch_ff[1])
        else $error("latch read mismatch");

    a_pin_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (cpu_req_in.rd && !cpu_req_in.rmw && cpu_req_in.port == 3'h3)
        |=> rdata_out == $past(pin_sync_ff[3*W +: W]))
        else $error("pin read mismatch");

    a_bus_port2: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        bus_cycle_in |=> pin_out[2*W +: W] == $past(bus_addr_in.addr_hi)
                         && pin_oe_n_out[2*W +: W] == '0)
        else $error("port 2 not on bus");

    a_p0_open_drain: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !$past(bus_cycle_in) |-> strong_pull_out[0 +: W] == '0)
        else $error("port 0 pull-up outside bus");

    a_latch_write: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (cpu_req_in.wr && cpu_req_in.port == 3'h1)
        |=> latch_ff[1] == $past(cpu_req_in.wdata[W-1:0]))
        else $error("latch write lost");

    a_quasi_drive: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        pin_oe_n_out[W +: W] == $past(latch_ff[1] & alt_out_in[W +: W]))
        else $error("port 1 driver not from latch");

    a_bus_port0: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_cycle_in && bus_addr_in.p0_drive)
        |=> pin_out[0 +: W] == $past(bus_addr_in.addr_lo) && pin_oe_n_out[0 +: W] == '0)
        else $error("port 0 not on bus");

    a_p4_released: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        pin_oe_n_out[NUM_PORTS*W-1 -: (W - PORT4_WIDTH)] == '1)
        else $error("unbuilt port 4 bit driven");

endmodule

// file: tb/plbp_ext_mem.sv
// Partner: pin environment and external address latch on the bus
// Assumes pins resolve from the design's active-low enables
module plbp_ext_mem
    import plbp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [39:0] pin_out_in,
    input  wire logic [39:0] oe_n_in,
    input  wire logic        ale_in,
    input  wire logic [39:0] ext_val_in,
    input  wire logic [39:0] ext_en_in,
    output logic      [39:0] pin_level_out,
    output logic      [7:0]  addr_lo_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] flt = 8'h55;

    // Released port 0 floats: a changing pattern, never a held level
    always @(posedge clk_in) flt <= ~flt;

    always_comb
    begin
        for (int i = 0; i < 40; i++)
            pin_level_out[i] = !oe_n_in[i] ? pin_out_in[i] :
                ext_en_in[i] ? ext_val_in[i] : (i < 8) ? flt[i] : 1'b1;
    end

    // Low address taken while the strobe is high
    always @(posedge clk_in)
    begin
        if (ale_in)
            addr_lo_out <= pin_level_out[7:0];
    end
endmodule

// file: tb/plbp_port_block_bench.sv
// Bench: drives the port block, its pins through the partner, and judges
// Assumes outputs registered one cycle after the request edge
module plbp_port_block_bench
    import plbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, tick = 0, dsm = 0, sdis = 0, xda = 0, bcyc = 0, efs = 1;
    plbp_bus_addr_type baddr = '0;
    plbp_cpu_req_type  req = '0;
    logic [39:0] alt = '1, ext_val = '0, ext_en = '0, pin_lvl, pout, oen;
    logic [7:0]  rdata, cap;
    logic [15:0] pull;
    logic        ale, program_store_strobe, cnt_en = 0;
    int n_mismatch = 0, num_checks = 0, cyc = 0, n_ale, n_ps;

    always #20 clk = ~clk;

    plbp_port_block dut (.core_clk_in(clk), .reset_n_in(rst_n), .osc_tick_in(tick),
        .double_speed_mode_in(dsm), .strobe_disable_in(sdis), .xdata_access_in(xda),
        .bus_cycle_in(bcyc), .bus_addr_in(baddr), .external_fetch_select_in(efs),
        .cpu_req_in(req), .alt_out_in(alt), .pin_in(pin_lvl), .rdata_out(rdata),
        .pin_out(pout), .pin_oe_n_out(oen), .strong_pull_out(pull),
        .addr_latch_strobe_out(ale), .program_store_strobe_out(program_store_strobe));

    plbp_ext_mem mem (.clk_in(clk), .pin_out_in(pout), .oe_n_in(oen), .ale_in(ale),
        .ext_val_in(ext_val), .ext_en_in(ext_en), .pin_level_out(pin_lvl),
        .addr_lo_out(cap));

    always @(posedge clk)
    begin
        cyc++;
        if (cnt_en)
        begin
            n_ale += ale;
            n_ps += program_store_strobe;
        end
        if (cyc == 6000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] p, input logic [7:0] d);
        req = '{1'b1, 1'b0, 1'b0, p, d};
        step();
        req = '0;
        // Idle edge so a following request never reassigns req in the same step
        step();
    endtask

    task automatic rd(input logic [2:0] p, input logic rmw, input logic [7:0] exp);
        req = '{1'b0, 1'b1, rmw, p, 8'h00};
        step();
        req = '0;
        chk("rdata", {32'h0, rdata}, {32'h0, exp});
        step();
    endtask

    // Counts strobes over n oscillator ticks, ticks every other cycle
    task automatic ticks(input int n, input logic xd, input int ea, input int ep);
        n_ale = 0;
        n_ps = 0;
        cnt_en = 1;
        for (int i = 0; i < n; i++)
        begin
            tick = 1;
            // Data access rides the first tick, an address strobe phase
            xda = xd && (i == 0);
            step();
            tick = 0;
            xda = 0;
            step();
        end
        step(3);
        cnt_en = 0;
        if (ea >= 0) chk("ale count", n_ale, ea);
        chk("program_store_strobe count", n_ps, ep);
    endtask

    task automatic t_reset();
        chk("oe_n", oen, '1);
        chk("pull", pull, 16'h0);
        for (int p = 0; p < 5; p++)
            rd(3'(p), 1'b1, (p == 4) ? 8'h1F : 8'hFF);
    endtask

    task automatic t_rereset();
        alt = '1;
        rst_n = 0;
        step(2);
        rst_n = 1;
        step(3);
        t_reset();
    endtask

    task automatic t_latch();
        for (int p = 0; p < 5; p++)
            wr(3'(p), 8'hA7 ^ 8'(p));
        for (int p = 0; p < 5; p++)
            rd(3'(p), 1'b1, (8'hA7 ^ 8'(p)) & ((p == 4) ? 8'h1F : 8'hFF));
        rd(3'h5, 1, 8'h00);
    endtask

    task automatic t_pins();
        wr(1, 8'hF0);
        ext_en[15:8] = 8'hFF;
        ext_val[15:8] = 8'hA5;
        step(3);
        chk("oe_n p1", oen[15:8], 8'hF0);
        rd(1, 0, 8'hA0);
        rd(1, 1, 8'hF0);
        wr(3, 8'hFF);
        alt[31:24] = 8'hFE;
        wr(0, 8'h0F);
        step(2);
        chk("oe_n p3", oen[31:24], 8'hFE);
        chk("oe_n p0", oen[7:0], 8'h0F);
        chk("pin p0", pout[7:0], 8'h00);
    endtask

    task automatic t_bus();
        baddr = '{8'h34, 8'h12, 1'b1};
        bcyc = 1;
        efs = 0;
        step(4);
        chk("p2 bus", {pout[23:16], oen[23:16], pull[15:8]}, 24'h120012);
        chk("p0 bus", {pout[7:0], oen[7:0], pull[7:0]}, 24'h340034);
        ticks(12, 0, -1, 2);
        chk("low address", cap, 8'h34);
        baddr.p0_drive = 0;
        step(2);
        chk("p0 released", {oen[7:0], pull[7:0]}, 16'hFF00);
        bcyc = 0;
        step(2);
        chk("after bus", {oen[23:16], oen[7:0], pull}, 32'hA50F0000);
        rd(2, 1, 8'hA5);
    endtask

    task automatic t_strobe();
        ticks(24, 0, 4, 4);
        dsm = 1;
        ticks(24, 0, 8, 8);
        dsm = 0;
        ticks(24, 1, -1, 2);
        chk("ale with data access", n_ale, 3);
        sdis = 1;
        ticks(24, 0, 4, 4);
        efs = 1;
        step(4);
        ticks(24, 0, 0, 0);
        sdis = 0;
        ticks(24, 0, 4, 0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        step(8);
        rst_n = 1;
        step(3);
        t_reset();
        t_latch();
        t_pins();
        t_bus();
        t_strobe();
        t_rereset();
        test_done();
    end
endmodule
